/* shared/asop_pkg.sv */
// Constants shared by the sample output pipeline
package asop_pkg;
    localparam int CODE_W = 8;
    localparam int SAMPLE_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [CODE_W-1:0] CODE_FULL = 8'hff;
    localparam logic [CODE_W-1:0] OUT_RESET = 8'h00;
    localparam int PIPE_RISE_EDGES = 3;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_TIME_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* verilog/asop_fifo.sv */
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ns
module asop_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [WIDTH-1:0] dout_r, dout_nxt;
    logic dval_r, dval_nxt;
    logic wr, rd, empty, full;

    always_comb begin
        empty = (wp_r == rp_r);
        full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
        in_ready_o = !full;
        wr = in_valid_i && !full;
        // Registered read stage; refill when empty or being taken
        rd = !empty && (!dval_r || out_ready_i);
        wp_nxt = wr ? wp_r + 1'b1 : wp_r;
        rp_nxt = rd ? rp_r + 1'b1 : rp_r;
        dout_nxt = rd ? mem_r[rp_r[AW-1:0]] : dout_r;
        dval_nxt = rd ? 1'b1 : (out_ready_i ? 1'b0 : dval_r);
        out_valid_o = dval_r;
        out_data_o = dout_r;
    end

    always_ff @(posedge clock_i) begin
        if (wr) begin
            mem_r[wp_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r <= '0;
            rp_r <= '0;
            dout_r <= '0;
            dval_r <= 1'b0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            dout_r <= dout_nxt;
            dval_r <= dval_nxt;
        end
    end
endmodule // asop_fifo

/* verilog/asop_pipeline.sv */
// Digital core of an 8-bit sampling converter output pipeline
`timescale 1ns/1ns

// Overview of operation
// - Input between bottom and top references quantises to an 8-bit code.
// - Input below bottom reference gives code of all zeros.
// - Input above top reference gives code of all ones if top is above bottom.
// - Each new sample is taken at the falling clock edge.
// - Code reaches output pins 2.5 cycles after sampling, plus output delay.
// - Conversion runs continuously, one sample per cycle, no start command.
// - Codes are straight unsigned binary; lowest input gives all zeros.
// - Power-down input low means normal; high enters low-power mode.
// - During power-down code_o holds the last completed code; the stream keeps draining.
// - With clock stopped, outputs keep the last code.
// - A fresh code appears every cycle once the pipeline is full.
// - Output updates follow the rising clock edge.
module asop_pipeline #(
    parameter int SAMPLE_W = asop_pkg::SAMPLE_W,
    parameter int CODE_W = asop_pkg::CODE_W,
    parameter int DEPTH = asop_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Digitised analog input and reference levels
    input wire logic [SAMPLE_W-1:0] analog_level_i,
    input wire logic [SAMPLE_W-1:0] bottom_reference_level_i,
    input wire logic [SAMPLE_W-1:0] top_reference_level_i,
    // Control
    input wire logic power_down_input_i,
    // Parallel code output
    output logic [CODE_W-1:0] code_o,
    output logic code_settled_o,
    // Buffered code stream
    output logic stream_valid_o,
    input wire logic stream_ready_i,
    output logic [CODE_W-1:0] stream_data_o,
    output logic stream_overflow_o
);
    localparam int CW = $clog2(asop_pkg::WAKE_CYCLES + 1);
    localparam int SPAN_W = SAMPLE_W + CODE_W;

    // Saturating straight-binary quantiser
    function automatic logic [CODE_W-1:0] quantise(
        input logic [SAMPLE_W-1:0] v,
        input logic [SAMPLE_W-1:0] lo,
        input logic [SAMPLE_W-1:0] hi
    );
        logic [SPAN_W-1:0] num;
        logic [SPAN_W-1:0] q;
        num = '0;
        q = '0;
        if (v <= lo || hi <= lo) begin
            quantise = asop_pkg::CODE_ZERO;
        end else if (v >= hi) begin
            quantise = asop_pkg::CODE_FULL;
        end else begin
            num = {{CODE_W{1'b0}}, v - lo} << CODE_W;
            q = num / {{CODE_W{1'b0}}, hi - lo};
            quantise = (q > SPAN_W'(asop_pkg::CODE_FULL)) ? asop_pkg::CODE_FULL : q[CODE_W-1:0];
        end
    endfunction

    logic [CODE_W-1:0] samp_r, samp_nxt;
    logic [CODE_W-1:0] s1_r, s1_nxt, s2_r, s2_nxt, out_r, out_nxt;
    logic [1:0] fill_r, fill_nxt;
    logic [CW-1:0] wake_r, wake_nxt;
    logic pd_q_r;
    logic push_ok, ovf_r, ovf_nxt;

    // Falling-edge sampler; power-down freezes acquisition
    always_comb begin
        samp_nxt = power_down_input_i ? samp_r
                 : quantise(analog_level_i, bottom_reference_level_i, top_reference_level_i);
    end

    always_ff @(negedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            samp_r <= asop_pkg::OUT_RESET;
        end else begin
            samp_r <= samp_nxt;
        end
    end

    // Rising-edge stages: falling sample lands on the third rising edge
    always_comb begin
        if (power_down_input_i) begin
            s1_nxt = s1_r;
            s2_nxt = s2_r;
            out_nxt = out_r;
            fill_nxt = fill_r;
        end else begin
            s1_nxt = samp_r;
            s2_nxt = s1_r;
            out_nxt = s2_r;
            fill_nxt = (fill_r == 2'h3) ? fill_r : fill_r + 2'h1;
        end
        // Settling window after leaving power-down
        if (power_down_input_i) begin
            wake_nxt = CW'(asop_pkg::WAKE_CYCLES);
        end else if (pd_q_r == 1'b0 && wake_r != '0) begin
            wake_nxt = wake_r - 1'b1;
        end else begin
            wake_nxt = wake_r;
        end
        ovf_nxt = ovf_r | (fill_r == 2'h3 && !power_down_input_i && !push_ok);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= asop_pkg::OUT_RESET;
            s2_r <= asop_pkg::OUT_RESET;
            out_r <= asop_pkg::OUT_RESET;
            fill_r <= 2'h0;
            wake_r <= '0;
            pd_q_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            out_r <= out_nxt;
            fill_r <= fill_nxt;
            wake_r <= wake_nxt;
            pd_q_r <= power_down_input_i;
            ovf_r <= ovf_nxt;
        end
    end

    assign code_o = out_r;
    // Advisory only; capturer still owns the settle rule
    assign code_settled_o = (wake_r == '0) && (fill_r == 2'h3) && !power_down_input_i;
    assign stream_overflow_o = ovf_r;

    // Stream copy of each fresh code; converter never stalls, so loss is flagged
    asop_fifo #(
        .WIDTH(CODE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(fill_r == 2'h3 && !power_down_input_i),
        .in_ready_o(push_ok),
        .in_data_i(out_r),
        .out_valid_o(stream_valid_o),
        .out_ready_i(stream_ready_i),
        .out_data_o(stream_data_o)
    );

    property p_pd_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        power_down_input_i |=> $stable(code_o);
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("code moved in power-down");
    property p_pd_freeze;
        @(negedge clock_i) disable iff (!rst_n_i)
        power_down_input_i |=> $stable(samp_r);
    endproperty
    a_pd_freeze: assert property (p_pd_freeze) else $error("sampler ran in power-down");
    property p_code_move;
        @(posedge clock_i) disable iff (!rst_n_i)
        $changed(code_o) |-> !$past(power_down_input_i);
    endproperty
    a_code_move: assert property (p_code_move) else $error("code changed without a running edge");
    // Three running edges must all lie before the checked edge, not end on it
    sequence s_run3;
        !power_down_input_i [*3];
    endsequence
    property p_latency;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_run3 |=> code_o == $past(samp_r, 3);
    endproperty
    a_latency: assert property (p_latency) else $error("pipeline latency wrong");
    property p_sat;
        @(negedge clock_i) disable iff (!rst_n_i)
        (!power_down_input_i && top_reference_level_i > bottom_reference_level_i
         && analog_level_i >= top_reference_level_i) |=> samp_r == asop_pkg::CODE_FULL;
    endproperty
    a_sat: assert property (p_sat) else $error("over-range not full code");
    property p_zero;
        @(negedge clock_i) disable iff (!rst_n_i)
        (!power_down_input_i && analog_level_i <= bottom_reference_level_i) |=> samp_r == asop_pkg::CODE_ZERO;
    endproperty
    a_zero: assert property (p_zero) else $error("under-range not zero code");
    property p_wake;
        @(posedge clock_i) disable iff (!rst_n_i)
        $fell(power_down_input_i) |-> !code_settled_o [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("settled too early");

    // Checker-only count of running edges since power-down, saturating
    localparam logic [CW-1:0] WAKE_MAX = CW'(asop_pkg::WAKE_CYCLES);
    logic [CW-1:0] lowrun_r, lowrun_nxt;

    always_comb begin
        if (power_down_input_i) begin
            lowrun_nxt = '0;
        end else if (lowrun_r != WAKE_MAX) begin
            lowrun_nxt = lowrun_r + 1'b1;
        end else begin
            lowrun_nxt = lowrun_r;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lowrun_r <= WAKE_MAX;
        end else begin
            lowrun_r <= lowrun_nxt;
        end
    end

    // Both ends of the settle window: never early, never later than one edge
    sequence s_awake;
        lowrun_r == WAKE_MAX && fill_r == 2'h3 && !power_down_input_i;
    endsequence
    sequence s_still_awake;
        !power_down_input_i;
    endsequence
    property p_settle_min;
        @(posedge clock_i) disable iff (!rst_n_i)
        code_settled_o |-> lowrun_r == WAKE_MAX;
    endproperty
    a_settle_min: assert property (p_settle_min) else $error("settled before wake time");
    property p_settle_max;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_awake ##1 s_still_awake |-> code_settled_o;
    endproperty
    a_settle_max: assert property (p_settle_max) else $error("settled flag late");
endmodule // asop_pipeline

/* verification/asop_capture_model.sv */
// Capturing logic beside the converter: registers codes, tracks wake time, drains stream
`timescale 1ns/1ns
module asop_capture_model (
    // Clock and control
    input wire logic clock_i,
    input wire logic power_down_input_i,
    input wire logic [1:0] mode_i,
    // From and to the converter
    input wire logic [7:0] code_i,
    output logic stream_ready_o,
    // To the bench
    output logic [7:0] cap_code_o,
    output logic trusted_o
);
    int wake_q = 0;
    always @(posedge clock_i) begin
        cap_code_o <= code_i;
        wake_q <= power_down_input_i ? 0 : wake_q + 1;
    end
    assign trusted_o = wake_q >= asop_pkg::WAKE_CYCLES;
    // Mode 2 starves the drain so the fifo reaches refusal; mode 1 drains on random cycles
    always @(negedge clock_i) stream_ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && $urandom_range(1, 0) == 1);
endmodule // asop_capture_model

/* verification/tb.sv */
// Self-checking bench for the sample output pipeline
`timescale 1ns/1ns
module tb;
    logic clock_i = 1'b0;
    logic clk_en = 1'b1;
    logic rst_n_i = 1'b0;
    logic pd = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [11:0] lvl = 12'h000;
    logic [11:0] lo = 12'h000;
    logic [11:0] hi = 12'hfff;
    logic [7:0] code, sdata, cap, held;
    logic settled, svalid, ovf, sready, trusted;
    logic [23:0] refs [5] = '{24'h000fff, 24'h100900, 24'h7ff800, 24'h800800, 24'h900100};
    logic [7:0] exp_q [$];
    logic [7:0] sb_q [$];
    bit sb_on = 1'b1;
    int runs = 0;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    always #10 if (clk_en) clock_i = ~clock_i;
    asop_pipeline i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .analog_level_i(lvl),
        .bottom_reference_level_i(lo), .top_reference_level_i(hi), .power_down_input_i(pd),
        .code_o(code), .code_settled_o(settled), .stream_valid_o(svalid), .stream_ready_i(sready),
        .stream_data_o(sdata), .stream_overflow_o(ovf));
    asop_capture_model i_cap (.clock_i(clock_i), .power_down_input_i(pd), .mode_i(mode),
        .code_i(code), .stream_ready_o(sready), .cap_code_o(cap), .trusted_o(trusted));
    task automatic final_report();
        $display("Errors %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(logic [7:0] got, logic [7:0] exp, string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] quant(logic [11:0] v, logic [11:0] l, logic [11:0] h);
        int q;
        if (h <= l || v <= l) return 8'h00;
        if (v >= h) return 8'hff;
        q = (int'(v) - int'(l)) * 256 / (int'(h) - int'(l));
        return (q > 255) ? 8'hff : 8'(q);
    endfunction
    // Captured copy lags code_o by one rising edge, hence five in flight
    task automatic step(logic [11:0] v);
        @(negedge clock_i);
        if (exp_q.size() == 5) check(cap, exp_q.pop_front(), "code");
        lvl <= v;
        exp_q.push_back(quant(v, lo, hi));
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            final_report();
        end
    end
    // Stream words must repeat code_o in order while nothing is being dropped
    always @(posedge clock_i) begin
        if (sb_on && svalid && sready) begin
            if (sb_q.size() == 0) begin
                err_count++;
                $display("Error at %0t: stream word with no code", $time);
            end else begin
                check(sdata, sb_q.pop_front(), "stream");
            end
        end
        if (rst_n_i && !pd) begin
            if (sb_on && runs >= 3) sb_q.push_back(code);
            if (runs < 3) runs++;
        end
    end
    initial begin
        void'($urandom(30));
        repeat (8) @(posedge clock_i);
        @(negedge clock_i) rst_n_i <= 1'b1;
        foreach (refs[i]) begin
            @(negedge clock_i) {lo, hi} <= refs[i];
            @(posedge clock_i);
            exp_q.delete();
            step(lo - 12'h001);
            step(lo);
            step(hi - 12'h001);
            step(hi);
            step(hi + 12'h001);
            repeat (30) step(12'($urandom));
        end
        check(8'(ovf), 8'h00, "ovf");
        mode <= 2'h2;
        sb_on = 1'b0;
        repeat (40) step(12'($urandom));
        check(8'(svalid), 8'h01, "full");
        check(8'(ovf), 8'h01, "ovf");
        held = code;
        pd <= 1'b1;
        for (int k = 0; k < 60; k++) begin
            @(negedge clock_i);
            lvl <= 12'($urandom);
            mode <= (k < 20) ? 2'h1 : 2'h0;
            check(code, held, "hold");
        end
        check(8'(settled), 8'h00, "pd");
        check(8'(svalid), 8'h00, "drain");
        pd <= 1'b0;
        sb_q.delete();
        sb_on = 1'b1;
        exp_q.delete();
        repeat (10) step(12'($urandom));
        check(8'(settled), 8'h00, "wake");
        repeat (50) step(12'($urandom));
        check(8'(settled), 8'(trusted), "wake");
        @(posedge clock_i) clk_en = 1'b0;
        #1 held = code;
        #500 check(code, held, "stop");
        clk_en = 1'b1;
        repeat (10) step(12'($urandom));
        final_report();
    end
endmodule // tb
